//--- xfer_consts.svh
// Opcodes, widths and reset values for the transfer executer
`ifndef XFER_CONSTS_SVH
`define XFER_CONSTS_SVH
`define OP_W 10
`define NIB_W 4
`define OP_TFR0A 10'h228
`define OP_TFR1A 10'h229
`define OP_TFR2A 10'h22a
`define OP_TFR3A 10'h22b
`define OP_TC1A 10'h2a8
`define OP_TK0A 10'h21b
`define OP_TAK0 10'h256
`define OP_TK1A 10'h214
`define OP_TAK1 10'h259
`define OP_TK2A 10'h215
`define OP_TAK2 10'h25a
`define OP_TPU0A 10'h22d
`define OP_TAPU0 10'h257
`define OP_TPU1A 10'h22e
`define OP_TAPU1 10'h25e
`define OP_TPU2A 10'h22f
`define OP_TAPU2 10'h25f
`define OP_TL1A 10'h20a
`define OP_TAL1 10'h24a
`define OP_TABSI 10'h278
`define OP_TSIAB 10'h238
`define OP_SERIAL_START 10'h29e
`define OP_SERIAL_TEST 10'h288
`define OP_TAJ1 10'h242
`define OP_TJ1A 10'h202
`define OP_RC_SELECT 10'h29b
`define OP_OSC_WRITE 10'h209
`define OP_TAMR 10'h252
`define OP_TMRA 10'h216
`define NIB_RST 4'h0
`define SIRQ_BIT 3
`endif

//--- xfer_pkg.sv
// Types shared by the transfer executer files
package xfer_pkg;
  typedef logic [3:0] nibble_t;
  typedef logic [9:0] opcode_t;
endpackage

//--- ctrl_nibble.sv
// One write-only-from-A control nibble register
`timescale 1ns/10ps
module ctrl_nibble #(
  parameter int W = 4
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic ce,
  input wire logic load,
  input wire logic [W-1:0] din,
  output logic [W-1:0] q
);
  if (W < 1) begin : g_bad_w
    $error("ctrl_nibble: W must be positive");
  end
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      q <= '0;
    end else if (ce && load) begin
      q <= din;
    end
  end
endmodule

//--- serial_flag.sv
// Serial done flag: hardware set wins over instruction clear
`timescale 1ns/10ps
module serial_flag (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic ce,
  input wire logic set_evt,
  input wire logic clr,
  output logic flag
);
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      flag <= 1'b0;
    end else if (ce) begin
      // Set beats a same-cycle clear so no completion is lost
      if (set_evt) begin
        flag <= 1'b1;
      end else if (clr) begin
        flag <= 1'b0;
      end
    end
  end
endmodule

//--- io_control_transfer_execution.sv
// Executes nibble transfers between A/B and peripheral control registers
`timescale 1ns/10ps
`include "xfer_consts.svh"
module io_control_transfer_execution #(
  parameter int SR_W = 8
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic ce,
  input wire logic instr_valid,
  input wire xfer_pkg::opcode_t instr_code,
  input wire logic skip_active,
  input wire xfer_pkg::nibble_t reg_a,
  input wire xfer_pkg::nibble_t reg_b,
  input wire xfer_pkg::nibble_t interrupt_ctrl_two,
  input wire logic [SR_W-1:0] serial_shift_in,
  input wire logic serial_xfer_done,
  output logic a_load,
  output xfer_pkg::nibble_t a_data,
  output logic b_load,
  output xfer_pkg::nibble_t b_data,
  output logic skip_next,
  output logic carry_write,
  output logic serial_shift_load,
  output logic [SR_W-1:0] serial_shift_data,
  output logic serial_start,
  output logic serial_done_flag,
  output xfer_pkg::nibble_t output_structure_ctrl_0,
  output xfer_pkg::nibble_t output_structure_ctrl_1,
  output xfer_pkg::nibble_t output_structure_ctrl_2,
  output xfer_pkg::nibble_t output_structure_ctrl_3,
  output xfer_pkg::nibble_t output_structure_ctrl_cport,
  output xfer_pkg::nibble_t key_wakeup_ctrl_0,
  output xfer_pkg::nibble_t key_wakeup_ctrl_1,
  output xfer_pkg::nibble_t key_wakeup_ctrl_2,
  output xfer_pkg::nibble_t key_wakeup_ctrl_lport,
  output xfer_pkg::nibble_t pullup_ctrl_0,
  output xfer_pkg::nibble_t pullup_ctrl_1,
  output xfer_pkg::nibble_t pullup_ctrl_2,
  output xfer_pkg::nibble_t serial_ctrl_register,
  output xfer_pkg::nibble_t clock_mode_register,
  output logic osc_select_register,
  output logic rc_osc_selected
);
  import xfer_pkg::*;

  if (SR_W != 2 * `NIB_W) begin : g_bad_sr_w
    $error("SR_W must be two nibbles");
  end

  logic go;
  assign go = ce && instr_valid && !skip_active;

  logic [`OP_W-1:0] op;
  assign op = instr_code;

  // Write strobes, one per register
  localparam int NW = 14;
  logic [NW-1:0] wr;
  assign wr[0] = go && (op == `OP_TFR0A);
  assign wr[1] = go && (op == `OP_TFR1A);
  assign wr[2] = go && (op == `OP_TFR2A);
  assign wr[3] = go && (op == `OP_TFR3A);
  assign wr[4] = go && (op == `OP_TC1A);
  assign wr[5] = go && (op == `OP_TK0A);
  assign wr[6] = go && (op == `OP_TK1A);
  assign wr[7] = go && (op == `OP_TK2A);
  assign wr[8] = go && (op == `OP_TL1A);
  assign wr[9] = go && (op == `OP_TPU0A);
  assign wr[10] = go && (op == `OP_TPU1A);
  assign wr[11] = go && (op == `OP_TPU2A);
  assign wr[12] = go && (op == `OP_TJ1A);
  assign wr[13] = go && (op == `OP_TMRA);

  nibble_t regs [NW];
  genvar gi;
  generate
    for (gi = 0; gi < NW; gi++) begin : g_reg
      ctrl_nibble #(.W(`NIB_W)) u_reg (
        .sys_clk(sys_clk),
        .reset(reset),
        .ce(ce),
        .load(wr[gi]),
        .din(reg_a),
        .q(regs[gi])
      );
    end
  endgenerate

  assign output_structure_ctrl_0 = regs[0];
  assign output_structure_ctrl_1 = regs[1];
  assign output_structure_ctrl_2 = regs[2];
  assign output_structure_ctrl_3 = regs[3];
  assign output_structure_ctrl_cport = regs[4];
  assign key_wakeup_ctrl_0 = regs[5];
  assign key_wakeup_ctrl_1 = regs[6];
  assign key_wakeup_ctrl_2 = regs[7];
  assign key_wakeup_ctrl_lport = regs[8];
  assign pullup_ctrl_0 = regs[9];
  assign pullup_ctrl_1 = regs[10];
  assign pullup_ctrl_2 = regs[11];
  assign serial_ctrl_register = regs[12];
  assign clock_mode_register = regs[13];

  // Read decode into A
  logic rd_kw0, rd_kw1, rd_kw2, rd_kwl, rd_p0, rd_p1, rd_p2, rd_sctl, rd_cmode, rd_si;
  assign rd_kw0 = go && (op == `OP_TAK0);
  assign rd_kw1 = go && (op == `OP_TAK1);
  assign rd_kw2 = go && (op == `OP_TAK2);
  assign rd_kwl = go && (op == `OP_TAL1);
  assign rd_p0 = go && (op == `OP_TAPU0);
  assign rd_p1 = go && (op == `OP_TAPU1);
  assign rd_p2 = go && (op == `OP_TAPU2);
  assign rd_sctl = go && (op == `OP_TAJ1);
  assign rd_cmode = go && (op == `OP_TAMR);
  assign rd_si = go && (op == `OP_TABSI);

  nibble_t next_a;
  assign next_a = rd_kw0 ? regs[5] :
                  rd_kw1 ? regs[6] :
                  rd_kw2 ? regs[7] :
                  rd_kwl ? regs[8] :
                  rd_p0 ? regs[9] :
                  rd_p1 ? regs[10] :
                  rd_p2 ? regs[11] :
                  rd_sctl ? regs[12] :
                  rd_cmode ? regs[13] :
                  serial_shift_in[`NIB_W-1:0];

  logic any_rd;
  assign any_rd = rd_kw0 | rd_kw1 | rd_kw2 | rd_kwl | rd_p0 | rd_p1 | rd_p2 |
                  rd_sctl | rd_cmode | rd_si;

  logic is_start, is_test, is_rc_sel, is_osc_wr, is_tsiab;
  assign is_start = go && (op == `OP_SERIAL_START);
  assign is_test = go && (op == `OP_SERIAL_TEST);
  assign is_rc_sel = go && (op == `OP_RC_SELECT);
  assign is_osc_wr = go && (op == `OP_OSC_WRITE);
  assign is_tsiab = go && (op == `OP_TSIAB);

  logic irq_en;
  assign irq_en = interrupt_ctrl_two[`SIRQ_BIT];

  // test clears and skips when the flag is set; no operation when enabled
  logic test_hit;
  assign test_hit = is_test && !irq_en && serial_done_flag;

  serial_flag u_flag (
    .sys_clk(sys_clk),
    .reset(reset),
    .ce(ce),
    .set_evt(serial_xfer_done),
    .clr(is_start || test_hit),
    .flag(serial_done_flag)
  );

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      a_load <= 1'b0;
      a_data <= `NIB_RST;
      b_load <= 1'b0;
      b_data <= `NIB_RST;
      skip_next <= 1'b0;
      serial_shift_load <= 1'b0;
      serial_shift_data <= '0;
      serial_start <= 1'b0;
    end else if (ce) begin
      a_load <= any_rd;
      a_data <= next_a;
      b_load <= rd_si;
      b_data <= serial_shift_in[SR_W-1:`NIB_W];
      skip_next <= test_hit;
      serial_shift_load <= is_tsiab;
      serial_shift_data <= {reg_b, reg_a};
      serial_start <= is_start;
    end
  end

  assign carry_write = 1'b0;

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      osc_select_register <= 1'b0;
      rc_osc_selected <= 1'b0;
    end else if (ce) begin
      if (is_osc_wr) begin
        osc_select_register <= reg_a[0];
      end
      if (is_rc_sel) begin
        rc_osc_selected <= 1'b1;
      end
    end
  end

  AST_START_CLEARS: assert property (@(posedge sys_clk) disable iff (reset)
    (is_start && !serial_xfer_done) |=> (!serial_done_flag && serial_start))
    else $error("serial start did not clear flag or pulse start");
  AST_START_DECODE: assert property (@(posedge sys_clk) disable iff (reset)
    (ce && instr_valid && !skip_active && instr_code == `OP_SERIAL_START) |=> serial_start)
    else $error("serial start code not taken in one cycle");
  AST_TEST_SKIP: assert property (@(posedge sys_clk) disable iff (reset)
    (is_test && !irq_en && serial_done_flag && !serial_xfer_done)
      |=> (skip_next && !serial_done_flag))
    else $error("serial test did not skip and clear");
  AST_TEST_NOP: assert property (@(posedge sys_clk) disable iff (reset)
    (is_test && irq_en && !serial_xfer_done)
      |=> (!skip_next && serial_done_flag == $past(serial_done_flag)))
    else $error("serial test acted while irq enabled");
  AST_SKIP_ONLY_TEST: assert property (@(posedge sys_clk) disable iff (reset)
    $rose(skip_next) |-> $past(test_hit))
    else $error("skip from non-test instruction");
  AST_SI_READ: assert property (@(posedge sys_clk) disable iff (reset)
    rd_si |=> (a_load && b_load && {b_data, a_data} == $past(serial_shift_in)))
    else $error("serial read split wrong");
  AST_SI_WRITE: assert property (@(posedge sys_clk) disable iff (reset)
    is_tsiab |=> (serial_shift_load && serial_shift_data == $past({reg_b, reg_a})))
    else $error("serial write data wrong");
  AST_OSC_BIT: assert property (@(posedge sys_clk) disable iff (reset)
    is_osc_wr |=> osc_select_register == $past(reg_a[0]))
    else $error("oscillator register missed A0");
  AST_OSC0_WRITE: assert property (@(posedge sys_clk) disable iff (reset)
    wr[0] |=> output_structure_ctrl_0 == $past(reg_a))
    else $error("output structure register 0 not written");
  AST_CPORT_WRITE: assert property (@(posedge sys_clk) disable iff (reset)
    wr[4] |=> output_structure_ctrl_cport == $past(reg_a))
    else $error("C-port output structure register not written");
  AST_KW0_WRITE: assert property (@(posedge sys_clk) disable iff (reset)
    wr[5] |=> key_wakeup_ctrl_0 == $past(reg_a))
    else $error("wakeup register 0 not written");
  AST_KW2_WRITE: assert property (@(posedge sys_clk) disable iff (reset)
    wr[7] |=> key_wakeup_ctrl_2 == $past(reg_a))
    else $error("wakeup register 2 not written");
  AST_LPORT_WRITE: assert property (@(posedge sys_clk) disable iff (reset)
    wr[8] |=> key_wakeup_ctrl_lport == $past(reg_a))
    else $error("L-port wakeup register not written");
  AST_PULLUP0_WRITE: assert property (@(posedge sys_clk) disable iff (reset)
    wr[9] |=> pullup_ctrl_0 == $past(reg_a))
    else $error("pull-up register 0 not written");
  AST_PULLUP1_READ: assert property (@(posedge sys_clk) disable iff (reset)
    rd_p1 |=> (a_load && a_data == $past(pullup_ctrl_1)))
    else $error("pull-up register 1 read wrong");
  AST_PULLUP2_READ: assert property (@(posedge sys_clk) disable iff (reset)
    rd_p2 |=> (a_load && a_data == $past(pullup_ctrl_2)))
    else $error("pull-up register 2 read wrong");
  AST_SCTL_READ: assert property (@(posedge sys_clk) disable iff (reset)
    rd_sctl |=> (a_load && a_data == $past(serial_ctrl_register)))
    else $error("serial control register read wrong");
  AST_CMODE_READ: assert property (@(posedge sys_clk) disable iff (reset)
    rd_cmode |=> (a_load && a_data == $past(clock_mode_register)))
    else $error("clock mode register read wrong");
  AST_KW1_ROUND: assert property (@(posedge sys_clk) disable iff (reset)
    (wr[6] ##1 (ce && instr_valid && !skip_active && op == `OP_TAK1))
      |=> (a_load && a_data == $past(reg_a, 2)))
    else $error("wakeup register 1 round trip failed");
  AST_SKIPPED_INERT: assert property (@(posedge sys_clk) disable iff (reset)
    (ce && skip_active) |=> (!a_load && !b_load && !serial_start && $stable(regs[13])))
    else $error("skipped instruction had an effect");
  AST_RC: assert property (@(posedge sys_clk) disable iff (reset)
    is_rc_sel |=> rc_osc_selected)
    else $error("RC oscillator not selected");
endmodule

//--- xfer_seq_model.sv
// Behavioural sequencer and serial unit facing the transfer executer
`timescale 1ns/10ps
module xfer_seq_model (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic skip_next,
  input wire logic serial_shift_load,
  input wire logic [7:0] serial_shift_data,
  input wire logic serial_start,
  output logic skip_active,
  output logic [7:0] serial_shift_in,
  output logic serial_xfer_done
);
  logic [2:0] busy;
  // Skip request marks the very next fetch slot
  assign skip_active = skip_next;
  always_ff @(posedge sys_clk) begin
    serial_xfer_done <= 1'b0;
    if (reset) begin
      busy <= 3'h0;
      serial_shift_in <= 8'h00;
    end else if (serial_shift_load) begin
      serial_shift_in <= serial_shift_data;
    end else if (serial_start) begin
      busy <= 3'h5;
    end else if (busy != 3'h0) begin
      busy <= busy - 3'h1;
      // Inverted result so received data never equals what was sent
      if (busy == 3'h1) begin
        serial_shift_in <= ~serial_shift_in;
        serial_xfer_done <= 1'b1;
      end
    end
  end
endmodule

//--- io_control_transfer_execution_tb.sv
// Self-checking bench for the transfer executer
`timescale 1ns/10ps
`include "xfer_consts.svh"
module io_control_transfer_execution_tb;
  import xfer_pkg::*;
  logic sys_clk, reset, ce, instr_valid, skip_active, xdone;
  logic a_load, b_load, skip_next, carry_write, sh_load, start, done_flag, osc_reg, rc_sel;
  opcode_t instr_code;
  nibble_t reg_a, reg_b, irq, a_data, b_data, v;
  logic [7:0] sh_data, sh_in, sent;
  nibble_t regs [14];
  nibble_t exp_regs [14];
  int compares, miscompares;
  opcode_t wr_op [14] = '{`OP_TFR0A, `OP_TFR1A, `OP_TFR2A, `OP_TFR3A, `OP_TC1A, `OP_TK0A,
    `OP_TK1A, `OP_TK2A, `OP_TPU0A, `OP_TPU1A, `OP_TPU2A, `OP_TL1A, `OP_TJ1A, `OP_TMRA};
  // Zero marks a write-only register
  opcode_t rd_op [14] = '{10'h000, 10'h000, 10'h000, 10'h000, 10'h000, `OP_TAK0, `OP_TAK1,
    `OP_TAK2, `OP_TAPU0, `OP_TAPU1, `OP_TAPU2, `OP_TAL1, `OP_TAJ1, `OP_TAMR};

  io_control_transfer_execution #(.SR_W(8)) u_io_control_transfer_execution (
    .sys_clk(sys_clk), .reset(reset), .ce(ce), .instr_valid(instr_valid),
    .instr_code(instr_code), .skip_active(skip_active), .reg_a(reg_a), .reg_b(reg_b),
    .interrupt_ctrl_two(irq), .serial_shift_in(sh_in), .serial_xfer_done(xdone),
    .a_load(a_load), .a_data(a_data), .b_load(b_load), .b_data(b_data),
    .skip_next(skip_next), .carry_write(carry_write), .serial_shift_load(sh_load),
    .serial_shift_data(sh_data), .serial_start(start), .serial_done_flag(done_flag),
    .output_structure_ctrl_0(regs[0]), .output_structure_ctrl_1(regs[1]),
    .output_structure_ctrl_2(regs[2]), .output_structure_ctrl_3(regs[3]),
    .output_structure_ctrl_cport(regs[4]), .key_wakeup_ctrl_0(regs[5]),
    .key_wakeup_ctrl_1(regs[6]), .key_wakeup_ctrl_2(regs[7]), .pullup_ctrl_0(regs[8]),
    .pullup_ctrl_1(regs[9]), .pullup_ctrl_2(regs[10]), .key_wakeup_ctrl_lport(regs[11]),
    .serial_ctrl_register(regs[12]), .clock_mode_register(regs[13]),
    .osc_select_register(osc_reg), .rc_osc_selected(rc_sel));

  xfer_seq_model u_xfer_seq_model (
    .sys_clk(sys_clk), .reset(reset), .skip_next(skip_next), .serial_shift_load(sh_load),
    .serial_shift_data(sh_data), .serial_start(start), .skip_active(skip_active),
    .serial_shift_in(sh_in), .serial_xfer_done(xdone));

  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end

  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    compares++;
    if (g !== e) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chk_regs();
    for (int j = 0; j < 14; j++) chk("ctrl_reg", exp_regs[j], regs[j]);
  endtask

  // Opcode taken at the second edge; outputs looked at just after it
  task automatic run(input opcode_t op, input nibble_t a, input nibble_t b);
    @(posedge sys_clk);
    instr_valid <= 1'b1;
    instr_code <= op;
    reg_a <= a;
    reg_b <= b;
    @(posedge sys_clk);
    instr_valid <= 1'b0;
    #1;
  endtask

  task automatic conclude();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic wait_flag();
    int n;
    n = 0;
    while (done_flag !== 1'b1 && n < 50) begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    chk("done_wait", 1, done_flag);
    if (done_flag !== 1'b1) conclude();
  endtask

  initial begin
    void'($urandom(32'h9b49));
    compares = 0;
    miscompares = 0;
    reset = 1'b1;
    ce = 1'b1;
    instr_valid = 1'b0;
    instr_code = 10'h000;
    reg_a = 4'h0;
    reg_b = 4'h0;
    irq = 4'h0;
    exp_regs = '{default: 4'h0};
    repeat (6) @(posedge sys_clk);
    reset <= 1'b0;
    #1;
    chk_regs();
    chk("flags", 0, {done_flag, rc_sel, osc_reg});
    $display("test reset done");
    repeat (2) begin
      for (int i = 0; i < 14; i++) begin
        v = 4'($urandom());
        run(wr_op[i], v, ~v);
        exp_regs[i] = v;
        chk_regs();
        chk("side", 0, {a_load, b_load, skip_next, carry_write});
        if (rd_op[i] != 10'h000) begin
          run(rd_op[i], ~v, v);
          chk("a_read", {1'b1, v}, {a_load, a_data});
        end
      end
    end
    // Write then read in adjacent slots must return the new value
    v = 4'($urandom());
    @(posedge sys_clk);
    instr_valid <= 1'b1;
    instr_code <= `OP_TK1A;
    reg_a <= v;
    @(posedge sys_clk);
    instr_code <= `OP_TAK1;
    reg_a <= ~v;
    @(posedge sys_clk);
    instr_valid <= 1'b0;
    exp_regs[6] = v;
    #1;
    chk("b2b_read", {1'b1, v}, {a_load, a_data});
    @(posedge sys_clk);
    ce <= 1'b0;
    run(`OP_TK0A, ~exp_regs[5], 4'h0);
    @(posedge sys_clk);
    ce <= 1'b1;
    run(10'h3ff, 4'hf, 4'hf);
    chk_regs();
    $display("test transfers done");
    sent = 8'($urandom());
    run(`OP_TSIAB, sent[3:0], sent[7:4]);
    chk("sh_load", 1, sh_load);
    chk("sh_write", sent, sh_data);
    run(`OP_TABSI, 4'h0, 4'h0);
    chk("ab_read", sent, {b_data, a_data});
    chk("ab_load", 2'b11, {b_load, a_load});
    run(`OP_SERIAL_START, 4'h0, 4'h0);
    chk("start", 2'b10, {start, done_flag});
    wait_flag();
    run(`OP_TABSI, 4'h0, 4'h0);
    chk("ab_first", ~sent, {b_data, a_data});
    @(posedge sys_clk);
    irq <= 4'h8;
    run(`OP_SERIAL_TEST, 4'h0, 4'h0);
    chk("test_irq_on", 2'b01, {skip_next, done_flag});
    run(`OP_SERIAL_START, 4'h0, 4'h0);
    chk("restart", 2'b10, {start, done_flag});
    wait_flag();
    // The partner inverts on every transfer, so two transfers give the word back
    run(`OP_TABSI, 4'h0, 4'h0);
    chk("ab_after", sent, {b_data, a_data});
    @(posedge sys_clk);
    irq <= 4'h7;
    // Back-to-back: the write lands in the skipped slot
    @(posedge sys_clk);
    instr_valid <= 1'b1;
    instr_code <= `OP_SERIAL_TEST;
    @(posedge sys_clk);
    instr_code <= `OP_TFR0A;
    reg_a <= ~exp_regs[0];
    #1;
    chk("test_skip", 2'b10, {skip_next, done_flag});
    @(posedge sys_clk);
    instr_valid <= 1'b0;
    #1;
    chk_regs();
    run(`OP_SERIAL_TEST, 4'h0, 4'h0);
    chk("no_skip", 0, skip_next);
    $display("test serial done");
    run(`OP_RC_SELECT, 4'h0, 4'h0);
    chk("rc_sel", 1, rc_sel);
    run(`OP_OSC_WRITE, 4'he, 4'h0);
    chk("osc_reg", 0, osc_reg);
    run(`OP_OSC_WRITE, 4'h1, 4'h0);
    chk("osc_reg", 1, osc_reg);
    run(`OP_OSC_WRITE, 4'he, 4'h0);
    chk("osc_reg", 0, osc_reg);
    $display("test clock done");
    conclude();
  end
endmodule
